/* shared/erx_fifo_if.sv */
`timescale 1ns/1ps
interface erx_fifo_if #(parameter int W = 32, parameter int AW = 10);
	logic push;
	logic [W-1:0] wdata;
	logic pop;
	logic skip;
	logic [AW:0] skip_n;
	logic flush;
	logic [W-1:0] rdata;
	logic [AW:0] count;
	logic full;
	logic empty;
	modport user(output push, wdata, pop, skip, skip_n, flush, input rdata, count, full, empty);
	modport store(input push, wdata, pop, skip, skip_n, flush, output rdata, count, full, empty);
endinterface

/* shared/erx_pkg.sv */
package erx_pkg;
	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int DATA_AW = 10;
	localparam int STAT_AW = 6;
	localparam int LEN_W = 12;
	localparam int SPACE_MARGIN = 3;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_DATA_PORT = 8'h00;
	localparam logic [7:0] OFF_STAT_PORT = 8'h04;
	localparam logic [7:0] OFF_FILL_INFO = 8'h08;
	localparam logic [7:0] OFF_RX_CFG = 8'h0c;
	localparam logic [7:0] OFF_DP_CTRL = 8'h10;
	localparam logic [7:0] OFF_MAC_CTRL = 8'h14;
	localparam logic [7:0] OFF_ERR_STAT = 8'h18;

	// ----------------------------------------
	// field positions and masks
	// ----------------------------------------
	localparam int CFG_PAD_EN_BIT = 0;
	localparam int CFG_BURST_LSB = 1;
	localparam int CFG_OFFS_LSB = 8;
	localparam int CFG_DUMP_BIT = 15;
	localparam logic [31:0] CFG_WMASK = 32'h0000_9f07;
	localparam int DP_SKIP_BIT = 31;
	localparam int MAC_RECEIVE_ENABLE_BIT_BIT = 2;
	localparam int MAC_SRST_BIT = 31;
	localparam int ERR_FLAG_BIT = 0;
	localparam int ERR_HALT_BIT = 1;
	localparam int INFO_STAT_LSB = 16;
	localparam int ST_ES_BIT = 15;
	localparam logic [31:0] ST_ES_SRC = 32'h0000_08c2;
	localparam logic [31:0] ST_KEEP_MASK = 32'h7fff_3cfe;

	// ----------------------------------------
	// reset values and answers
	// ----------------------------------------
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam logic RECEIVE_ENABLE_BIT_RST = 1'b0;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		W_IDLE,
		W_OFFS,
		W_DATA,
		W_TAIL,
		W_PAD,
		W_STAT
	} erx_wstate_t;
endpackage

/* src/erx_fifo.sv */
`timescale 1ns/1ps
module erx_fifo #(
	parameter int W = 32,
	parameter int AW = 10
) (
	input wire logic aclk,
	input wire logic aresetn,
	erx_fifo_if.store f
);
	localparam int DEPTH = 1 << AW;
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0] cnt;
	logic do_push;
	logic [AW:0] adv;

	assign f.full = (cnt == FULL_CNT);
	assign f.empty = (cnt == '0);
	assign f.count = cnt;
	assign f.rdata = mem[rp];
	assign do_push = f.push && !f.full;
	// skip moves the read side skip_n entries at once
	assign adv = f.skip ? f.skip_n : (AW+1)'(f.pop && !f.empty);

	// ----------------------------------------
	// storage
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (do_push) begin
			mem[wp] <= f.wdata;
		end
	end

	// ----------------------------------------
	// pointers
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn || f.flush) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end else begin
			wp <= wp + AW'(do_push);
			rp <= rp + adv[AW-1:0];
			cnt <= cnt + (AW+1)'(do_push) - adv;
		end
	end
endmodule

/* src/erx_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - mac words enter data fifo, pointer advances
// - status word last, into separate fifo
// - fill info shows data and status counts
// - status pops independent of data reads
// - empty read flags underrun and error
// - per-packet start offset of 0-31 bytes
// - optional zero pad to burst multiple
// - offset and pad applied per packet
// - skip bit discards head data packet
// - skip leaves status fifo untouched
// - skip works while frames keep arriving
// - dump resets all fifo pointers
// - dump bit clears itself after flush
// - status word fixed field layout
// - bit 15 ors bits 11,7,6,1
// - status underrun and overrun flag error
// - enable cleared halts, pulse halted irq
module erx_top #(
	parameter int DATA_AW = erx_pkg::DATA_AW,
	parameter int STAT_AW = erx_pkg::STAT_AW
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic mac_rx_side_valid,
	output logic mac_rx_side_ready,
	input wire logic [31:0] mac_rx_side_data,
	input wire logic mac_rx_side_last,
	input wire logic [1:0] mac_rx_side_bytes,
	input wire logic mac_rx_side_is_status,
	output logic rx_error_flag,
	output logic receiver_halted_irq,
	output logic receive_enable
);
	localparam int LW = erx_pkg::LEN_W;
	localparam logic [DATA_AW:0] SPACE_LIM =
		(DATA_AW+1)'((1 << DATA_AW) - erx_pkg::SPACE_MARGIN);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
		return a[7:2] == off[7:2];
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		return is_reg(a, erx_pkg::OFF_DATA_PORT) || is_reg(a, erx_pkg::OFF_STAT_PORT) ||
			is_reg(a, erx_pkg::OFF_FILL_INFO) || is_reg(a, erx_pkg::OFF_RX_CFG) ||
			is_reg(a, erx_pkg::OFF_DP_CTRL) || is_reg(a, erx_pkg::OFF_MAC_CTRL) ||
			is_reg(a, erx_pkg::OFF_ERR_STAT);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] fmt_status(input logic [31:0] raw);
		logic [31:0] s;
		s = raw & erx_pkg::ST_KEEP_MASK;
		s[erx_pkg::ST_ES_BIT] = |(raw & erx_pkg::ST_ES_SRC);
		return s;
	endfunction

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	erx_fifo_if #(.W(32), .AW(DATA_AW)) dq();
	erx_fifo_if #(.W(32), .AW(STAT_AW)) sq();
	erx_fifo_if #(.W(LW), .AW(STAT_AW)) lq();

	erx_pkg::erx_wstate_t state;
	logic aw_got;
	logic w_got;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_go;
	logic rd_go;
	logic [31:0] rd_mux;
	logic [31:0] rx_cfg;
	logic soft_rst;
	logic skip_bit;
	logic halted;
	logic flush;
	logic d_pop;
	logic d_under;
	logic s_pop;
	logic s_under;
	logic s_over;
	logic head_valid;
	logic [LW-1:0] head_left;
	logic skip_go;
	logic [1:0] sh;
	logic [2:0] fill;
	logic [LW-1:0] wcount;
	logic [31:0] carry;
	logic hs_data;
	logic hs_stat;
	logic space_ok;
	logic pad_need;
	logic tail_need;
	logic [5:0] shamt;
	logic [LW-1:0] pad_mask;

	// ----------------------------------------
	// fifos
	// ----------------------------------------
	erx_fifo #(.W(32), .AW(DATA_AW)) u_data (.aclk(aclk), .aresetn(aresetn), .f(dq.store));
	erx_fifo #(.W(32), .AW(STAT_AW)) u_stat (.aclk(aclk), .aresetn(aresetn), .f(sq.store));
	erx_fifo #(.W(LW), .AW(STAT_AW)) u_len (.aclk(aclk), .aresetn(aresetn), .f(lq.store));

	assign flush = rx_cfg[erx_pkg::CFG_DUMP_BIT] || soft_rst;
	assign dq.flush = flush;
	assign sq.flush = flush;
	assign lq.flush = flush;
	assign dq.pop = d_pop;
	assign dq.skip = skip_go;
	assign dq.skip_n = (DATA_AW+1)'(head_left);
	assign sq.pop = s_pop;
	assign sq.skip = 1'b0;
	assign sq.skip_n = '0;
	assign lq.skip = 1'b0;
	assign lq.skip_n = '0;
	assign lq.pop = !head_valid && !lq.empty && !flush;

	// ----------------------------------------
	// receive write side
	// ----------------------------------------
	assign hs_data = mac_rx_side_valid && mac_rx_side_ready && state == erx_pkg::W_DATA &&
		!mac_rx_side_is_status;
	assign hs_stat = mac_rx_side_valid && mac_rx_side_ready && state == erx_pkg::W_STAT &&
		mac_rx_side_is_status;
	assign space_ok = dq.count < SPACE_LIM;
	assign shamt = {1'b0, sh, 3'b000};
	assign pad_mask = (LW'(4) << rx_cfg[erx_pkg::CFG_BURST_LSB +: 2]) - LW'(1);
	assign pad_need = rx_cfg[erx_pkg::CFG_PAD_EN_BIT] && ((wcount & pad_mask) != '0);
	assign tail_need = ({1'b0, sh} + ((mac_rx_side_bytes == 2'b00) ? 3'd4 :
		{1'b0, mac_rx_side_bytes})) > 3'd4;

	always_comb begin
		dq.push = 1'b0;
		dq.wdata = '0;
		unique case (state)
			erx_pkg::W_OFFS: dq.push = (fill != 3'd0) && !dq.full;
			erx_pkg::W_DATA: begin
				dq.push = hs_data && !dq.full;
				dq.wdata = (mac_rx_side_data << shamt) | carry;
			end
			erx_pkg::W_TAIL: begin
				dq.push = !dq.full;
				dq.wdata = carry;
			end
			erx_pkg::W_PAD: dq.push = pad_need && !dq.full;
			erx_pkg::W_IDLE, erx_pkg::W_STAT: dq.push = 1'b0;
		endcase
	end

	assign sq.push = hs_stat && !sq.full;
	assign sq.wdata = fmt_status(mac_rx_side_data);
	assign lq.push = hs_stat && !lq.full;
	assign lq.wdata = wcount;
	assign s_over = hs_stat && sq.full;

	always_ff @(posedge aclk) begin
		if (!aresetn || flush) begin
			state <= erx_pkg::W_IDLE;
			mac_rx_side_ready <= 1'b0;
			sh <= '0;
			fill <= '0;
			wcount <= '0;
			carry <= '0;
		end else begin
			unique case (state)
				erx_pkg::W_IDLE: begin
					if (receive_enable && mac_rx_side_valid && !mac_rx_side_is_status) begin
						sh <= rx_cfg[erx_pkg::CFG_OFFS_LSB +: 2];
						fill <= rx_cfg[erx_pkg::CFG_OFFS_LSB + 2 +: 3];
						wcount <= '0;
						carry <= '0;
						state <= erx_pkg::W_OFFS;
					end
				end
				erx_pkg::W_OFFS: begin
					if (fill == 3'd0) begin
						state <= erx_pkg::W_DATA;
						mac_rx_side_ready <= space_ok;
					end else if (dq.push) begin
						fill <= fill - 3'd1;
						wcount <= wcount + LW'(1);
					end
				end
				erx_pkg::W_DATA: begin
					if (hs_data && mac_rx_side_last) begin
						carry <= mac_rx_side_data >> (6'd32 - shamt);
						wcount <= wcount + LW'(1);
						mac_rx_side_ready <= 1'b0;
						state <= tail_need ? erx_pkg::W_TAIL : erx_pkg::W_PAD;
					end else begin
						if (hs_data) begin
							carry <= mac_rx_side_data >> (6'd32 - shamt);
							wcount <= wcount + LW'(1);
						end
						mac_rx_side_ready <= space_ok;
					end
				end
				erx_pkg::W_TAIL: begin
					if (dq.push) begin
						wcount <= wcount + LW'(1);
						state <= erx_pkg::W_PAD;
					end
				end
				erx_pkg::W_PAD: begin
					if (!pad_need) begin
						state <= erx_pkg::W_STAT;
						mac_rx_side_ready <= 1'b1;
					end else if (dq.push) begin
						wcount <= wcount + LW'(1);
					end
				end
				erx_pkg::W_STAT: begin
					if (hs_stat) begin
						mac_rx_side_ready <= 1'b0;
						state <= erx_pkg::W_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// head packet tracking and skip
	// ----------------------------------------
	assign skip_go = skip_bit && head_valid && !flush;

	always_ff @(posedge aclk) begin
		if (!aresetn || flush) begin
			head_valid <= 1'b0;
			head_left <= '0;
		end else if (skip_go) begin
			head_valid <= 1'b0;
		end else if (!head_valid && !lq.empty) begin
			head_left <= lq.rdata - LW'(d_pop);
			head_valid <= !(d_pop && lq.rdata == LW'(1));
		end else if (d_pop && head_valid) begin
			head_left <= head_left - LW'(1);
			head_valid <= head_left != LW'(1);
		end
	end

	// ----------------------------------------
	// axi4-lite write channels
	// ----------------------------------------
	assign wr_go = aw_got && w_got && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			aw_got <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_got <= 1'b1;
			aw_addr <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (wr_go) begin
			aw_got <= 1'b0;
		end else if (!aw_got) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b0;
			w_got <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_got <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (wr_go) begin
			w_got <= 1'b0;
		end else if (!w_got) begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= erx_pkg::RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= is_mapped(aw_addr) ? erx_pkg::RESP_OKAY : erx_pkg::RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn || soft_rst) begin
			rx_cfg <= erx_pkg::CFG_RST;
		end else if (wr_go && is_reg(aw_addr, erx_pkg::OFF_RX_CFG)) begin
			rx_cfg <= merge(rx_cfg, w_data, w_strb) & erx_pkg::CFG_WMASK;
		end else begin
			rx_cfg[erx_pkg::CFG_DUMP_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			receive_enable <= erx_pkg::RECEIVE_ENABLE_BIT_RST;
			soft_rst <= 1'b0;
		end else if (wr_go && is_reg(aw_addr, erx_pkg::OFF_MAC_CTRL)) begin
			if (w_strb[0]) begin
				receive_enable <= w_data[erx_pkg::MAC_RECEIVE_ENABLE_BIT_BIT];
			end
			soft_rst <= w_strb[3] && w_data[erx_pkg::MAC_SRST_BIT];
		end else begin
			soft_rst <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || flush) begin
			skip_bit <= 1'b0;
		end else if (skip_go) begin
			skip_bit <= 1'b0;
		end else if (wr_go && is_reg(aw_addr, erx_pkg::OFF_DP_CTRL) && w_strb[3] &&
			w_data[erx_pkg::DP_SKIP_BIT]) begin
			skip_bit <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_error_flag <= 1'b0;
		end else if (d_under || s_under || s_over) begin
			rx_error_flag <= 1'b1;
		end else if (soft_rst || (wr_go && is_reg(aw_addr, erx_pkg::OFF_ERR_STAT) &&
			w_strb[0] && w_data[erx_pkg::ERR_FLAG_BIT])) begin
			rx_error_flag <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			halted <= 1'b1;
			receiver_halted_irq <= 1'b0;
		end else begin
			halted <= !receive_enable && state == erx_pkg::W_IDLE;
			receiver_halted_irq <= !halted && !receive_enable && state == erx_pkg::W_IDLE;
		end
	end

	// ----------------------------------------
	// axi4-lite read channel
	// ----------------------------------------
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign d_pop = rd_go && is_reg(s_axi_araddr, erx_pkg::OFF_DATA_PORT) && !dq.empty;
	assign d_under = rd_go && is_reg(s_axi_araddr, erx_pkg::OFF_DATA_PORT) && dq.empty;
	assign s_pop = rd_go && is_reg(s_axi_araddr, erx_pkg::OFF_STAT_PORT) && !sq.empty;
	assign s_under = rd_go && is_reg(s_axi_araddr, erx_pkg::OFF_STAT_PORT) && sq.empty;

	always_comb begin
		rd_mux = '0;
		if (is_reg(s_axi_araddr, erx_pkg::OFF_DATA_PORT)) begin
			rd_mux = dq.empty ? 32'h0000_0000 : dq.rdata;
		end else if (is_reg(s_axi_araddr, erx_pkg::OFF_STAT_PORT)) begin
			rd_mux = sq.empty ? 32'h0000_0000 : sq.rdata;
		end else if (is_reg(s_axi_araddr, erx_pkg::OFF_FILL_INFO)) begin
			rd_mux = {8'h00, 8'(sq.count), 16'(dq.count)};
		end else if (is_reg(s_axi_araddr, erx_pkg::OFF_RX_CFG)) begin
			rd_mux = rx_cfg;
		end else if (is_reg(s_axi_araddr, erx_pkg::OFF_DP_CTRL)) begin
			rd_mux = 32'(skip_bit) << erx_pkg::DP_SKIP_BIT;
		end else if (is_reg(s_axi_araddr, erx_pkg::OFF_MAC_CTRL)) begin
			rd_mux = 32'(receive_enable) << erx_pkg::MAC_RECEIVE_ENABLE_BIT_BIT;
		end else if (is_reg(s_axi_araddr, erx_pkg::OFF_ERR_STAT)) begin
			rd_mux = (32'(halted) << erx_pkg::ERR_HALT_BIT) |
				(32'(rx_error_flag) << erx_pkg::ERR_FLAG_BIT);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= erx_pkg::RESP_OKAY;
		end else if (rd_go) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= is_mapped(s_axi_araddr) ? erx_pkg::RESP_OKAY : erx_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end
endmodule

/* verif/erx_mac_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// mac side frame source
// ----------------------------------------
module erx_mac_model (
	input wire logic aclk,
	input wire logic ready,
	output logic valid,
	output logic [31:0] data,
	output logic last,
	output logic [1:0] bytes,
	output logic is_status,
	output logic hung
);
	initial begin
		valid = 1'b0;
		data = 32'h0;
		last = 1'b0;
		bytes = 2'h0;
		is_status = 1'b0;
		hung = 1'b0;
	end
	// one beat, random idle gap of 0-2 cycles before it, held until taken or 300 cycles pass
	task automatic beat(input logic [31:0] d, input logic l, s, input logic [1:0] b);
		int g;
		int i;
		g = $urandom % 3;
		if (g != 0) begin
			valid <= 1'b0;
			data <= ~data;
			repeat (g) @(posedge aclk);
		end
		valid <= 1'b1;
		data <= d;
		last <= l;
		is_status <= s;
		bytes <= b;
		for (i = 0; i < 300; i++) begin
			@(posedge aclk);
			if (ready) break;
		end
		if (i == 300) hung <= 1'b1;
	endtask
	// data words, then the status word as final beat
	task automatic send(input logic [31:0] w[$], input int lb, input logic [31:0] st);
		for (int i = 0; i < w.size(); i++) beat(w[i], i == w.size() - 1, 1'b0, lb[1:0]);
		beat(st, 1'b0, 1'b1, 2'h0);
		valid <= 1'b0;
		data <= ~st;
		@(posedge aclk);
	endtask
endmodule

/* verif/erx_top_monitor.sv */
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module erx_top_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic mac_rx_side_valid,
	input wire logic mac_rx_side_ready,
	input wire logic mac_rx_side_last,
	input wire logic mac_rx_side_is_status,
	input wire logic rx_error_flag,
	input wire logic receiver_halted_irq,
	input wire logic receive_enable
);
	logic pop_q;
	logic stat_q;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// host read handshake and status beat of the last cycle
	always_ff @(posedge aclk) begin
		pop_q <= s_axi_arvalid && s_axi_arready;
		stat_q <= mac_rx_side_valid && mac_rx_side_ready && mac_rx_side_is_status;
	end
	property p_read_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read answer late");
	property p_read_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_read_hold: assert property (p_read_hold) else $error("read data moved");
	property p_write_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("no write answer");
	property p_err_cause;
		$rose(rx_error_flag) |-> pop_q || stat_q;
	endproperty
	a_err_cause: assert property (p_err_cause) else $error("error without cause");
	property p_err_clear;
		$fell(rx_error_flag) |-> s_axi_bvalid || $past(s_axi_bvalid);
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("error dropped alone");
	property p_irq_pulse;
		receiver_halted_irq |=> !receiver_halted_irq;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("halt pulse too long");
	property p_irq_cause;
		receiver_halted_irq |-> !receive_enable;
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("halt pulse while on");
	property p_last_drop;
		mac_rx_side_valid && mac_rx_side_ready && mac_rx_side_last && !mac_rx_side_is_status
			|=> !mac_rx_side_ready;
	endproperty
	a_last_drop: assert property (p_last_drop) else $error("ready after last");
	property p_status_drop;
		mac_rx_side_valid && mac_rx_side_ready && mac_rx_side_is_status |=> !mac_rx_side_ready;
	endproperty
	a_status_drop: assert property (p_status_drop) else $error("ready after status");
endmodule
bind erx_top erx_top_monitor mon_u (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.mac_rx_side_valid(mac_rx_side_valid), .mac_rx_side_ready(mac_rx_side_ready),
	.mac_rx_side_last(mac_rx_side_last), .mac_rx_side_is_status(mac_rx_side_is_status),
	.rx_error_flag(rx_error_flag), .receiver_halted_irq(receiver_halted_irq),
	.receive_enable(receive_enable));

/* verif/erx_top_tb.sv */
`timescale 1ns/1ps
module erx_top_tb;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d, s1, s2;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic m_valid, m_ready, m_last, m_stat, m_hung, err, irq, receive_enable_bit;
	logic [31:0] m_data;
	logic [1:0] m_bytes;
	logic [31:0] w1[$], w2[$], e1[$], e2[$], k1[$], k2[$];
	int failures, n_checks, lb1, lb2, off, pad, sel;
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	erx_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .mac_rx_side_valid(m_valid),
		.mac_rx_side_ready(m_ready), .mac_rx_side_data(m_data), .mac_rx_side_last(m_last),
		.mac_rx_side_bytes(m_bytes), .mac_rx_side_is_status(m_stat), .rx_error_flag(err),
		.receiver_halted_irq(irq), .receive_enable(receive_enable_bit));
	erx_mac_model mac_u (.aclk(aclk), .ready(m_ready), .valid(m_valid), .data(m_data),
		.last(m_last), .bytes(m_bytes), .is_status(m_stat), .hung(m_hung));
	task automatic end_of_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int i;
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
		@(posedge aclk);
		if (i == 100) begin failures++; end_of_test(); end
	endtask
	task automatic rd(input logic [7:0] a);
		int i;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
		if (i == 100) begin failures++; end_of_test(); end
	endtask
	task automatic wait_info(input int n);
		for (int i = 0; i < 60; i++) begin
			rd(erx_pkg::OFF_FILL_INFO);
			if (d[23:16] == n) break;
		end
		chk("status count", n, {24'h0, d[23:16]});
	endtask
	function automatic logic [31:0] stat_exp(input logic [31:0] s);
		return (s & erx_pkg::ST_KEEP_MASK) | {16'h0, |(s & erx_pkg::ST_ES_SRC), 15'h0};
	endfunction
	// expected words and known-byte masks of one packet
	function automatic void build(input logic [31:0] w[$], input int lb,
			output logic [31:0] e[$], output logic [31:0] m[$]);
		logic [7:0] b[$];
		logic k[$];
		int nb, tw;
		nb = 4 * (w.size() - 1) + (lb == 0 ? 4 : lb);
		tw = (off + nb + 3) / 4;
		e = {};
		m = {};
		for (int i = 0; i < off + nb; i++) begin
			b.push_back(i < off ? 8'h00 : w[(i - off) / 4][8 * ((i - off) % 4) +: 8]);
			k.push_back(i >= off);
		end
		while (b.size() % 4 != 0 || (pad != 0 && (b.size() / 4) % (4 << sel) != 0)) begin
			k.push_back(b.size() / 4 >= tw);
			b.push_back(8'h00);
		end
		for (int i = 0; i < b.size(); i += 4) begin
			e.push_back({b[i + 3], b[i + 2], b[i + 1], b[i]});
			m.push_back({{8{k[i + 3]}}, {8{k[i + 2]}}, {8{k[i + 1]}}, {8{k[i]}}});
		end
	endfunction
	task automatic mk(input int nmin, output logic [31:0] w[$], output int lb,
			output logic [31:0] st);
		w = {};
		repeat (nmin + $urandom % 4) w.push_back($urandom);
		lb = $urandom % 4;
		st = $urandom;
	endtask
	task automatic read_pkt(input logic [31:0] e[$], m[$]);
		foreach (e[i]) begin
			rd(erx_pkg::OFF_DATA_PORT);
			chk("data word", e[i] & m[i], d & m[i]);
		end
	endtask
	initial begin
		void'($urandom(3));
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(erx_pkg::OFF_FILL_INFO);
		chk("fill after reset", 32'h0, d);
		wr(erx_pkg::OFF_MAC_CTRL, 32'h4);
		chk("receive enable", 32'h1, {31'h0, receive_enable_bit});
		for (int n = 0; n < 6; n++) begin
			off = n == 0 ? 31 : n == 1 ? 0 : $urandom % 32;
			pad = n == 0 ? 1 : $urandom % 2;
			sel = n == 0 ? 3 : $urandom % 4;
			wr(erx_pkg::OFF_RX_CFG, pad | (sel << 1) | (off << 8));
			mk(1, w1, lb1, s1);
			mk(1, w2, lb2, s2);
			mac_u.send(w1, lb1, s1);
			mac_u.send(w2, lb2, s2);
			wait_info(2);
			build(w1, lb1, e1, k1);
			build(w2, lb2, e2, k2);
			chk("data count", e1.size() + e2.size(), {16'h0, d[15:0]});
			rd(erx_pkg::OFF_STAT_PORT);
			chk("status", stat_exp(s1), d);
			rd(erx_pkg::OFF_STAT_PORT);
			chk("status", stat_exp(s2), d);
			read_pkt(e1, k1);
			read_pkt(e2, k2);
		end
		off = 0;
		pad = 0;
		wr(erx_pkg::OFF_RX_CFG, 32'h0);
		mk(4, w1, lb1, s1);
		mk(1, w2, lb2, s2);
		mac_u.send(w1, lb1, s1);
		wait_info(1);
		fork
			mac_u.send(w2, lb2, s2);
			begin
				wr(erx_pkg::OFF_DP_CTRL, 32'h8000_0000);
				for (int i = 0; i < 50; i++) begin
					rd(erx_pkg::OFF_DP_CTRL);
					if (d[31] === 1'b0) break;
				end
				chk("skip bit", 32'h0, {31'h0, d[31]});
			end
		join
		wait_info(2);
		build(w2, lb2, e2, k2);
		chk("data count", e2.size(), {16'h0, d[15:0]});
		rd(erx_pkg::OFF_STAT_PORT);
		chk("status", stat_exp(s1), d);
		rd(erx_pkg::OFF_STAT_PORT);
		read_pkt(e2, k2);
		mac_u.send(w1, lb1, s1);
		wait_info(1);
		fork
			wr(erx_pkg::OFF_MAC_CTRL, 32'h0);
			begin
				for (int i = 0; i < 40 && irq !== 1'b1; i++) @(posedge aclk);
				chk("halt pulse", 32'h1, {31'h0, irq});
			end
		join
		chk("receive enable", 32'h0, {31'h0, receive_enable_bit});
		wr(erx_pkg::OFF_RX_CFG, 32'h8000);
		rd(erx_pkg::OFF_RX_CFG);
		chk("dump bit", 32'h0, {31'h0, d[15]});
		rd(erx_pkg::OFF_FILL_INFO);
		chk("fill after dump", 32'h0, d);
		rd(erx_pkg::OFF_DATA_PORT);
		chk("underrun data", 32'h0, d);
		chk("error flag", 32'h1, {31'h0, err});
		wr(erx_pkg::OFF_ERR_STAT, 32'h1);
		chk("error flag", 32'h0, {31'h0, err});
		rd(erx_pkg::OFF_STAT_PORT);
		chk("error flag", 32'h1, {31'h0, err});
		wr(erx_pkg::OFF_MAC_CTRL, 32'h8000_0000);
		chk("error flag", 32'h0, {31'h0, err});
		rd(8'h40);
		chk("unmapped read", {30'h0, erx_pkg::RESP_SLVERR}, {30'h0, r});
		wr(8'h40, 32'h1);
		chk("unmapped write", {30'h0, erx_pkg::RESP_SLVERR}, {30'h0, r});
		chk("mac stall", 32'h0, {31'h0, m_hung});
		end_of_test();
	end
endmodule
